/* verilog/rail_seq_pkg.sv */
`default_nettype none
package rail_seq_pkg;
	// Register offsets on the serial register port
	localparam logic [7:0] EVENT_STATUS_OFS   = 8'h2b;
	localparam logic [7:0] SEQ_PRIORITY_A_OFS = 8'h2c;
	localparam logic [7:0] SEQ_PRIORITY_B_OFS = 8'h2d;
	// Event status bit positions
	localparam int FORCED_SHDN_BIT = 7;
	localparam int BUTTON_RISE_BIT = 6;
	localparam int BUTTON_FALL_BIT = 5;
	localparam int HOT_HIGH_BIT    = 1;
	localparam int HOT_LOW_BIT     = 0;
	// Reset values
	localparam logic [7:0] STATUS_RESET = 8'h00;
	localparam logic [7:0] RDATA_RESET  = 8'h00;
	// Priority codes
	localparam logic [3:0] PRIO_OFF   = 4'h0;
	localparam logic [3:0] PRIO_FIRST = 4'h1;
	localparam logic [3:0] PRIO_LAST  = 4'hc;
	// Gap between two sequence steps
	localparam int STEP_TIME_US  = 1000;
	localparam int CLK_MHZ       = 100;
	localparam int STEP_CYCLES   = STEP_TIME_US * CLK_MHZ;
	localparam int STEP_CNT_W    = 17;
	// Sequencer states, Gray along idle-up-down
	typedef enum logic [1:0] {
		SEQ_IDLE = 2'b00,
		SEQ_UP   = 2'b01,
		SEQ_DOWN = 2'b11
	} seq_state_t;
endpackage
`default_nettype wire

/* verilog/rail_slot.sv */
`timescale 1ns/10ps
`default_nettype none
// One converter enable, switched when the current step equals its priority
module rail_slot
	import rail_seq_pkg::*;
(
	input  wire logic       i_ref_clk,
	input  wire logic       i_rst,
	input  wire logic [3:0] i_priority, // Priority field from its register
	input  wire logic [3:0] i_step,     // Step being applied
	input  wire logic       i_apply,    // One-cycle step strobe
	input  wire logic       i_up,       // High for power-up, low for power-down
	output logic            o_en        // Converter enable
);
	logic en_ff;   // Enable state
	logic in_seq;  // Field names a legal step

	// Off and reserved codes never join the sequence
	assign in_seq = (i_priority >= PRIO_FIRST) && (i_priority <= PRIO_LAST);

	// Turn on at own step going up, off at own step going down
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			en_ff <= 1'b0;
		end else if (i_apply && in_seq && (i_step == i_priority)) begin
			en_ff <= i_up;
		end
	end

	assign o_en = en_ff;
endmodule
`default_nettype wire

/* verilog/rail_sequence_priority_and_event_status.sv */
// Functional notes
// - Sticky read-only flag on button rising edge
// - Falling-edge flag one bit below rising flag
// - Two temperature pre-warning flags, bits 1/0
// - Code 0 excluded, 1 first, 12 last
// - Up ascending, down in reverse order
// - First register upper nibble: converter 2
// - First register lower nibble: converter 1
// - Second register upper nibble: converter 4
`timescale 1ns/10ps
`default_nettype none
module rail_sequence_priority_and_event_status
	import rail_seq_pkg::*;
#(
	parameter logic [7:0] SEQ_A_OPTION = 8'h21,       // Factory option, converters 2 and 1
	parameter logic [7:0] SEQ_B_OPTION = 8'h30,       // Factory option, converter 4
	parameter int         STEP_CNT     = STEP_CYCLES  // Cycles between sequence steps
) (
	input  wire logic       i_ref_clk,
	input  wire logic       i_rst,
	input  wire logic       i_power_button_input, // Button pin, asynchronous
	input  wire logic       i_forced_shutdown,    // Forced shutdown event pulse
	input  wire logic       i_hot_high,           // Higher temperature comparator
	input  wire logic       i_hot_low,            // Lower temperature comparator
	input  wire logic       i_seq_up,             // Power-up request pulse
	input  wire logic       i_seq_down,           // Power-down request pulse
	input  wire logic [7:0] i_reg_addr,           // Register address
	input  wire logic       i_reg_wr,             // Write strobe
	input  wire logic       i_reg_rd,             // Read strobe
	input  wire logic [7:0] i_reg_wdata,          // Write data
	output logic      [7:0] o_reg_rdata,          // Read data, registered
	output logic      [2:0] o_conv_en,            // Enables: [0] conv1, [1] conv2, [2] conv4
	output logic            o_seq_busy            // Sequence in progress
);
	logic [1:0]  btn_meta_ff;    // Button synchroniser stage one (bit 0) and two (bit 1)
	logic        btn_prev_ff;    // Button delayed for edge detect
	logic [1:0]  hot_meta_ff;    // Temperature stage one
	logic [1:0]  hot_sync_ff;    // Temperature stage two
	logic [7:0]  status_ff;      // Event status byte
	logic [7:0]  nxt_status;     // Next status
	logic [7:0]  status_set;     // Events this cycle
	logic        status_rd;      // Status read clears flags
	logic [7:0]  seq_a_ff;       // Converter 2 / converter 1 priorities
	logic [3:0]  seq_b_ff;       // Converter 4 priority
	logic [7:0]  rdata_ff;       // Read data
	logic [STEP_CNT_W-1:0] step_cnt_ff; // Step gap counter
	logic        step_tick;      // Step gap elapsed
	logic [3:0]  step_ff;        // Current step number
	seq_state_t  state_ff;       // Sequencer state
	logic        btn_sync;       // Synchronised button level

	assign btn_sync = btn_meta_ff[1];

	// Two-flop synchronisers for the pins
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			btn_meta_ff <= 2'h0;
			btn_prev_ff <= 1'b0;
			hot_meta_ff <= 2'h0;
			hot_sync_ff <= 2'h0;
		end else begin
			btn_meta_ff <= {btn_meta_ff[0], i_power_button_input};
			btn_prev_ff <= btn_meta_ff[1];
			hot_meta_ff <= {i_hot_high, i_hot_low};
			hot_sync_ff <= hot_meta_ff;
		end
	end

	// Event sources gathered into status positions
	always_comb begin
		status_set                  = 8'h00;
		status_set[FORCED_SHDN_BIT] = i_forced_shutdown;
		status_set[BUTTON_RISE_BIT] = btn_sync & ~btn_prev_ff;
		status_set[BUTTON_FALL_BIT] = ~btn_sync & btn_prev_ff;
		status_set[HOT_HIGH_BIT]    = hot_sync_ff[1];
		status_set[HOT_LOW_BIT]     = hot_sync_ff[0];
	end

	assign status_rd  = i_reg_rd && (i_reg_addr == EVENT_STATUS_OFS);
	// Clear on read; a new event in the same cycle wins
	assign nxt_status = status_set | (status_ff & {8{~status_rd}});

	// Sticky event status byte
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			status_ff <= STATUS_RESET;
		end else begin
			status_ff <= nxt_status;
		end
	end

	// Priority registers, loaded from the factory option at reset
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			seq_a_ff <= SEQ_A_OPTION;
			seq_b_ff <= SEQ_B_OPTION[7:4];
		end else if (i_reg_wr) begin
			if (i_reg_addr == SEQ_PRIORITY_A_OFS) begin
				seq_a_ff <= i_reg_wdata;
			end else if (i_reg_addr == SEQ_PRIORITY_B_OFS) begin
				seq_b_ff <= i_reg_wdata[7:4];
			end
		end
	end

	// Read data; unmapped and reserved bits read zero
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			rdata_ff <= RDATA_RESET;
		end else if (i_reg_rd) begin
			if (i_reg_addr == EVENT_STATUS_OFS) begin
				rdata_ff <= {status_ff[7:5], 3'h0, status_ff[1:0]};
			end else if (i_reg_addr == SEQ_PRIORITY_A_OFS) begin
				rdata_ff <= seq_a_ff;
			end else if (i_reg_addr == SEQ_PRIORITY_B_OFS) begin
				rdata_ff <= {seq_b_ff, 4'h0};
			end else begin
				rdata_ff <= 8'h00;
			end
		end
	end

	// Step gap divider, runs only while sequencing
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			step_cnt_ff <= '0;
		end else if ((state_ff == SEQ_IDLE) || step_tick) begin
			step_cnt_ff <= '0;
		end else begin
			step_cnt_ff <= step_cnt_ff + 1'b1;
		end
	end

	assign step_tick = (step_cnt_ff == STEP_CNT_W'(STEP_CNT - 1)) && (state_ff != SEQ_IDLE);

	// Sequencer: walks steps 1..12 up, or 12..1 down
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			state_ff <= SEQ_IDLE;
			step_ff  <= PRIO_OFF;
		end else begin
			case (state_ff)
				SEQ_IDLE: begin
					if (i_seq_up) begin
						state_ff <= SEQ_UP;
						step_ff  <= PRIO_FIRST;
					end else if (i_seq_down) begin
						state_ff <= SEQ_DOWN;
						step_ff  <= PRIO_LAST;
					end
				end
				SEQ_UP: begin
					if (step_tick) begin
						if (step_ff == PRIO_LAST) begin
							state_ff <= SEQ_IDLE;
						end else begin
							step_ff <= step_ff + 4'h1;
						end
					end
				end
				SEQ_DOWN: begin
					if (step_tick) begin
						if (step_ff == PRIO_FIRST) begin
							state_ff <= SEQ_IDLE;
						end else begin
							step_ff <= step_ff - 4'h1;
						end
					end
				end
				default: begin
					state_ff <= SEQ_IDLE;
				end
			endcase
		end
	end

	// Converter 1 slot
	rail_slot u_conv1 (
		.i_ref_clk (i_ref_clk),
		.i_rst     (i_rst),
		.i_priority(seq_a_ff[3:0]),
		.i_step    (step_ff),
		.i_apply   (step_tick),
		.i_up      (state_ff == SEQ_UP),
		.o_en      (o_conv_en[0])
	);
	// Converter 2 slot
	rail_slot u_conv2 (
		.i_ref_clk (i_ref_clk),
		.i_rst     (i_rst),
		.i_priority(seq_a_ff[7:4]),
		.i_step    (step_ff),
		.i_apply   (step_tick),
		.i_up      (state_ff == SEQ_UP),
		.o_en      (o_conv_en[1])
	);
	// Converter 4 slot
	rail_slot u_conv4 (
		.i_ref_clk (i_ref_clk),
		.i_rst     (i_rst),
		.i_priority(seq_b_ff),
		.i_step    (step_ff),
		.i_apply   (step_tick),
		.i_up      (state_ff == SEQ_UP),
		.o_en      (o_conv_en[2])
	);

	assign o_reg_rdata = rdata_ff;
	assign o_seq_busy  = (state_ff != SEQ_IDLE);

	// Checks
	rise_flag_set_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		(btn_sync && !btn_prev_ff) |=> status_ff[BUTTON_RISE_BIT])
		else $error("button rise not flagged");
	fall_flag_set_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		(!btn_sync && btn_prev_ff) |=> status_ff[BUTTON_FALL_BIT])
		else $error("button fall not flagged");
	hot_high_flag_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		hot_sync_ff[1] |=> status_ff[HOT_HIGH_BIT])
		else $error("high warning not flagged");
	hot_low_flag_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		hot_sync_ff[0] |=> status_ff[HOT_LOW_BIT])
		else $error("low warning not flagged");
	seq_a_write_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		(i_reg_wr && i_reg_addr == SEQ_PRIORITY_A_OFS) |=> seq_a_ff == $past(i_reg_wdata))
		else $error("first priority register not written");
	seq_b_write_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		(i_reg_wr && i_reg_addr == SEQ_PRIORITY_B_OFS) |=> seq_b_ff == $past(i_reg_wdata[7:4]))
		else $error("second priority register not written");
	conv1_up_step_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		(state_ff == SEQ_UP && step_tick && step_ff == seq_a_ff[3:0]) |=> o_conv_en[0])
		else $error("converter 1 missed its step");
	up_range_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		(state_ff != SEQ_IDLE) |-> (step_ff >= PRIO_FIRST && step_ff <= PRIO_LAST))
		else $error("step outside legal range");
	down_end_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		(state_ff == SEQ_DOWN && step_tick && step_ff == PRIO_FIRST) |=> state_ff == SEQ_IDLE)
		else $error("power-down did not finish at step one");
	reserved_off_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		(seq_b_ff > PRIO_LAST && !o_conv_en[2]) |=> !o_conv_en[2])
		else $error("reserved code switched converter 4");
	up_seen_c: cover property (@(posedge i_ref_clk) disable iff (i_rst)
		state_ff == SEQ_UP && step_tick && step_ff == PRIO_LAST);
	down_seen_c: cover property (@(posedge i_ref_clk) disable iff (i_rst)
		state_ff == SEQ_DOWN && step_tick && step_ff == PRIO_FIRST);
	clear_race_c: cover property (@(posedge i_ref_clk) disable iff (i_rst)
		status_rd && status_set[BUTTON_RISE_BIT]);
endmodule
`default_nettype wire

/* tb/host_model.sv */
`timescale 1ns/10ps
`default_nettype none
// Host side of the register strobe port, standing in for the serial master
module host_model (
	input  wire logic       i_ref_clk,   // Reference clock
	input  wire logic [7:0] i_reg_rdata, // Read data from the block
	output logic      [7:0] o_reg_addr,  // Register address
	output logic            o_reg_wr,    // Write strobe
	output logic            o_reg_rd,    // Read strobe
	output logic      [7:0] o_reg_wdata  // Write data
);
	// Idle port at time zero
	initial begin
		o_reg_addr  = 8'hff;
		o_reg_wr    = 1'b0;
		o_reg_rd    = 1'b0;
		o_reg_wdata = 8'hff;
	end

	// One write, launched and released at falling edges
	task automatic write(input logic [7:0] a, input logic [7:0] d);
		@(negedge i_ref_clk);
		o_reg_addr  = a;
		o_reg_wdata = d;
		o_reg_wr    = 1'b1;
		@(negedge i_ref_clk);
		o_reg_wr    = 1'b0;
		o_reg_addr  = ~a;
		o_reg_wdata = ~d;
	endtask

	// One read; data is registered on the taking edge
	task automatic read(input logic [7:0] a, output logic [7:0] d);
		@(negedge i_ref_clk);
		o_reg_addr = a;
		o_reg_rd   = 1'b1;
		@(negedge i_ref_clk);
		o_reg_rd   = 1'b0;
		o_reg_addr = ~a;
		d          = i_reg_rdata;
	endtask
endmodule
`default_nettype wire

/* tb/testbench.sv */
`timescale 1ns/10ps
`default_nettype none
module testbench;
	import rail_seq_pkg::*;
	localparam int         STEP  = 4;     // Shortened step gap
	localparam int         LIMIT = 2000;  // Cycle ceiling
	localparam logic [7:0] OPT_A = 8'h21; // Factory option, first register
	localparam logic [7:0] OPT_B = 8'h30; // Factory option, second register
	logic       i_ref_clk;              // Clock
	logic       i_rst;                  // Reset
	logic [3:0] ev;                     // Forced, button, hot high, hot low
	logic       seq_up;                 // Power-up request
	logic       seq_down;               // Power-down request
	logic [7:0] reg_addr;               // Register address
	logic [7:0] reg_wdata;              // Write data
	logic [7:0] reg_rdata;              // Read data
	logic       reg_wr;                 // Write strobe
	logic       reg_rd;                 // Read strobe
	logic [2:0] conv_en;                // Converter enables
	logic       seq_busy;               // Sequencer busy
	logic [7:0] rd;                     // Last read value
	int         errors;                 // Mismatch count
	int         checked;                // Comparison count
	int         cycles;                 // Clock count
	int         t[3];                   // Switch time of each enable

	host_model host_model_inst (.i_ref_clk(i_ref_clk), .i_reg_rdata(reg_rdata),
		.o_reg_addr(reg_addr), .o_reg_wr(reg_wr), .o_reg_rd(reg_rd), .o_reg_wdata(reg_wdata));

	rail_sequence_priority_and_event_status #(.SEQ_A_OPTION(OPT_A), .SEQ_B_OPTION(OPT_B),
		.STEP_CNT(STEP)) rail_sequence_priority_and_event_status_inst (
		.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_power_button_input(ev[2]),
		.i_forced_shutdown(ev[3]), .i_hot_high(ev[1]), .i_hot_low(ev[0]),
		.i_seq_up(seq_up), .i_seq_down(seq_down), .i_reg_addr(reg_addr), .i_reg_wr(reg_wr),
		.i_reg_rd(reg_rd), .i_reg_wdata(reg_wdata), .o_reg_rdata(reg_rdata),
		.o_conv_en(conv_en), .o_seq_busy(seq_busy));

	// Free-running clock
	initial begin
		i_ref_clk = 1'b0;
		forever #5 i_ref_clk = ~i_ref_clk;
	end

	// Cuts a hang short
	always @(posedge i_ref_clk) begin
		cycles++;
		if (cycles == LIMIT) begin
			errors++;
			summarize();
		end
	end

	// Counts and verdict
	task automatic summarize();
		$display("errors %0d checked %0d", errors, checked);
		if (errors == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// One comparison
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Read a register and compare
	task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
		host_model_inst.read(a, rd);
		chk(rd, exp);
	endtask

	// Raise events, drop all but the button level, read twice to see the clear
	task automatic event_read(input logic [3:0] v, input logic [7:0] exp);
		ev = v;
		repeat (2) @(negedge i_ref_clk);
		ev = v & 4'h4;
		repeat (4) @(negedge i_ref_clk);
		rdchk(EVENT_STATUS_OFS, exp);
		rdchk(EVENT_STATUS_OFS, 8'h00);
	endtask

	// Request a sequence, inject a refused opposite request, log switch times
	task automatic run_seq(input logic up, input logic [2:0] fin);
		int n;
		t = '{-1, -1, -1};
		// Let an edge pass so back-to-back calls never drive a request twice at once
		@(negedge i_ref_clk);
		seq_up   = up;
		seq_down = ~up;
		for (n = 0; n < 20 * STEP && (n < 2 || seq_busy === 1'b1); n++) begin
			@(negedge i_ref_clk);
			seq_up   = (n == 8) && !up;
			seq_down = (n == 8) && up;
			for (int b = 0; b < 3; b++)
				if (t[b] < 0 && conv_en[b] === up)
					t[b] = n;
		end
		chk({5'h00, conv_en}, {5'h00, fin});
		chk({7'h00, seq_busy}, 8'h00);
	endtask

	// Main sequence
	initial begin
		errors   = 0;
		checked  = 0;
		cycles   = 0;
		ev       = 4'h0;
		seq_up   = 1'b0;
		seq_down = 1'b0;
		i_rst    = 1'b1;
		repeat (12) @(negedge i_ref_clk);
		i_rst = 1'b0;
		rdchk(SEQ_PRIORITY_A_OFS, OPT_A);
		rdchk(SEQ_PRIORITY_B_OFS, {OPT_B[7:4], 4'h0});
		rdchk(EVENT_STATUS_OFS, 8'h00);
		host_model_inst.write(EVENT_STATUS_OFS, 8'hff);
		host_model_inst.write(8'h40, 8'h55);
		rdchk(EVENT_STATUS_OFS, 8'h00);
		rdchk(8'h40, 8'h00);
		host_model_inst.write(SEQ_PRIORITY_A_OFS, 8'h12);
		host_model_inst.write(SEQ_PRIORITY_B_OFS, 8'hc5);
		rdchk(SEQ_PRIORITY_A_OFS, 8'h12);
		rdchk(SEQ_PRIORITY_B_OFS, 8'hc0);
		run_seq(1'b1, 3'h7);
		chk(8'(t[0] - t[1]), 8'(STEP));
		chk(8'(t[2] - t[0]), 8'(10 * STEP));
		run_seq(1'b0, 3'h0);
		chk(8'(t[1] - t[0]), 8'(STEP));
		chk(8'(t[0] - t[2]), 8'(10 * STEP));
		host_model_inst.write(SEQ_PRIORITY_A_OFS, 8'hd0);
		host_model_inst.write(SEQ_PRIORITY_B_OFS, 8'hf0);
		rdchk(SEQ_PRIORITY_A_OFS, 8'hd0);
		run_seq(1'b1, 3'h0);
		host_model_inst.write(SEQ_PRIORITY_B_OFS, 8'h10);
		run_seq(1'b1, 3'h4);
		run_seq(1'b0, 3'h0);
		event_read(4'h4, 8'h40);
		event_read(4'h0, 8'h20);
		event_read(4'h8, 8'h80);
		event_read(4'h2, 8'h02);
		event_read(4'h1, 8'h01);
		event_read(4'h3, 8'h03);
		summarize();
	end
endmodule
`default_nettype wire
